// >>> src/fpt_pkg.sv
// Constants shared by the flat panel timing generator.
// Assumes a 32-bit AHB-Lite register port and a separate dot clock domain.
package fpt_pkg;

  // ----------------------------------------
  // Register byte offsets and reset value
  // ----------------------------------------
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_DOTCLK     = 8'h04;
  localparam logic [7:0]  ADDR_HTIME      = 8'h08;
  localparam logic [7:0]  ADDR_VTIME      = 8'h0C;
  localparam logic [7:0]  ADDR_PIXEL      = 8'h10;
  localparam logic [7:0]  ADDR_STATUS     = 8'h14;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_TYPE_LSB      = 0;
  localparam int CTRL_RES_LSB       = 4;
  localparam int CTRL_BPP16_BIT     = 8;
  localparam int CTRL_BACKLIGHT_BIT = 12;
  localparam int CTRL_PATTERN_BIT   = 16;
  localparam int TIM_FP_LSB         = 0;
  localparam int TIM_SYNC_LSB       = 8;
  localparam int TIM_BP_LSB         = 16;
  localparam int PIX_B_LSB          = 0;
  localparam int PIX_G_LSB          = 6;
  localparam int PIX_R_LSB          = 12;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_VBLANK_BIT    = 1;
  localparam int STAT_FRAMES_LSB    = 16;

  // ----------------------------------------
  // Widths and timing constants
  // ----------------------------------------
  localparam int         CNT_W       = 13;
  localparam int         H_UNIT_SH   = 3;
  localparam logic [1:0] TYPE_OFF    = 2'h0;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY  = 2'h0;

  typedef enum logic [1:0] {
    RES_640  = 2'b00,
    RES_800  = 2'b01,
    RES_1024 = 2'b10
  } fpt_res_t;

  localparam logic [CNT_W-1:0] W_640  = 13'd640;
  localparam logic [CNT_W-1:0] H_480  = 13'd480;
  localparam logic [CNT_W-1:0] W_800  = 13'd800;
  localparam logic [CNT_W-1:0] H_600  = 13'd600;
  localparam logic [CNT_W-1:0] W_1024 = 13'd1024;
  localparam logic [CNT_W-1:0] H_768  = 13'd768;

  typedef enum logic [1:0] {
    PH_ACT  = 2'b00,
    PH_FP   = 2'b01,
    PH_SYNC = 2'b10,
    PH_BP   = 2'b11
  } fpt_phase_t;

endpackage

// >>> src/fpt_top.sv
// Flat panel timing generator: AHB-Lite registers on hclk, scan logic on pix_clk.
// Assumes pix_clk comes from a clock source already set to the dot clock rate.
//
// Notes on behaviour
// - Dot clock runs continuously, times every pixel.
// - Three six-bit colour buses, MSB bit 5.
// - Line sync period and retrace pulse.
// - Frame sync period and retrace pulse.
// - Active display only on visible pixels.
// - Data enable exactly when pixel data valid.
// - Backlight enable controlled by configuration.
// - Line total = active+porch+sync+porch.
// - Frame total = active+porch+sync+porch lines.
// - Horizontal porch and sync counts times eight.
// - Vertical porch and sync in whole lines.
// - 640x480, 800x600, 1024x768, 8/16 bpp.
// - Dot clock MHz and porches, reset zero.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

module fpt_top
  import fpt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  output logic [7:0]       dot_clk_mhz,
  input  wire logic        pix_clk,
  output logic             dot_clk_out,
  output logic [5:0]       red_out,
  output logic [5:0]       green_out,
  output logic [5:0]       blue_out,
  output logic             line_sync_out,
  output logic             frame_sync_out,
  output logic             active_display_flag,
  output logic             data_enable_out,
  output logic             backlight_en_out,
  output logic             panel_vdd_en_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic fpt_phase_t phase_of(
    input logic [CNT_W-1:0] c,
    input logic [CNT_W-1:0] act_end,
    input logic [CNT_W-1:0] fp_end,
    input logic [CNT_W-1:0] sync_end
  );
    if (c < act_end) begin
      return PH_ACT;
    end else if (c < fp_end) begin
      return PH_FP;
    end else if (c < sync_end) begin
      return PH_SYNC;
    end else begin
      return PH_BP;
    end
  endfunction

  function automatic logic [CNT_W-1:0] field8(input logic [31:0] w, input int lsb);
    return {5'h0_0, w[lsb +: 8]};
  endfunction

  // ----------------------------------------
  // AHB-Lite slave, hclk domain
  // ----------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] htime_ff;
  logic [31:0] vtime_ff;
  logic [31:0] pixel_ff;
  logic [7:0]  dotclk_ff;
  logic [7:0]  addr_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [31:0] hrdata_ff;
  logic        take;
  logic        cfg_busy;
  logic        vblank_s1_ff;
  logic        vblank_s2_ff;
  logic [15:0] frames_ff;

  assign take      = hsel && hready && (htrans == HTRANS_NSEQ);
  assign hresp     = HRESP_OKAY;
  // Reads cost one wait state so read data always comes from a flop
  assign hreadyout = !rd_pend_ff;
  assign hrdata    = hrdata_ff;
  assign dot_clk_mhz = dotclk_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff    <= 8'h00;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= take && hwrite;
      rd_pend_ff <= take && !hwrite;
      if (take) begin
        addr_ff <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Settings reset to zero; type zero means panel disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff   <= REG_RESET;
      htime_ff  <= REG_RESET;
      vtime_ff  <= REG_RESET;
      pixel_ff  <= REG_RESET;
      dotclk_ff <= 8'h00;
    end else if (wr_pend_ff) begin
      case (addr_ff)
        ADDR_CTRL:   ctrl_ff   <= hwdata;
        ADDR_DOTCLK: dotclk_ff <= hwdata[7:0];
        ADDR_HTIME:  htime_ff  <= hwdata & 32'h00FF_FFFF;
        ADDR_VTIME:  vtime_ff  <= hwdata & 32'h00FF_FFFF;
        ADDR_PIXEL:  pixel_ff  <= hwdata & 32'h0003_FFFF;
        default:     ctrl_ff   <= ctrl_ff;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_pend_ff) begin
      case (addr_ff)
        ADDR_CTRL:   hrdata_ff <= ctrl_ff;
        ADDR_DOTCLK: hrdata_ff <= {24'h00_0000, dotclk_ff};
        ADDR_HTIME:  hrdata_ff <= htime_ff;
        ADDR_VTIME:  hrdata_ff <= vtime_ff;
        ADDR_PIXEL:  hrdata_ff <= pixel_ff;
        ADDR_STATUS: hrdata_ff <= {frames_ff, 14'h0000, vblank_s2_ff, cfg_busy};
        default:     hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Settings hand-over to the dot clock domain
  // ----------------------------------------
  // Live registers are snapshotted; the snapshot stays frozen until the pixel
  // side acknowledges, so the pixel side never samples a word in motion.
  logic        dirty_ff;
  logic        req_tgl_ff;
  logic        ack_s1_ff;
  logic        ack_s2_ff;
  logic [31:0] snap_ctrl_ff;
  logic [31:0] snap_htime_ff;
  logic [31:0] snap_vtime_ff;
  logic [31:0] snap_pixel_ff;

  assign cfg_busy = req_tgl_ff ^ ack_s2_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dirty_ff      <= 1'b0;
      req_tgl_ff    <= 1'b0;
      snap_ctrl_ff  <= REG_RESET;
      snap_htime_ff <= REG_RESET;
      snap_vtime_ff <= REG_RESET;
      snap_pixel_ff <= REG_RESET;
    end else begin
      if (dirty_ff && !cfg_busy) begin
        snap_ctrl_ff  <= ctrl_ff;
        snap_htime_ff <= htime_ff;
        snap_vtime_ff <= vtime_ff;
        snap_pixel_ff <= pixel_ff;
        req_tgl_ff    <= !req_tgl_ff;
      end
      // A write in the same cycle as the snapshot keeps the flag set
      if (wr_pend_ff) begin
        dirty_ff <= 1'b1;
      end else if (!cfg_busy) begin
        dirty_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Status back from the dot clock domain
  // ----------------------------------------
  logic frame_tgl_px_ff;
  logic vblank_px_ff;
  logic ack_tgl_px_ff;
  logic ftg_s1_ff;
  logic ftg_s2_ff;
  logic ftg_s3_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_s1_ff    <= 1'b0;
      ack_s2_ff    <= 1'b0;
      vblank_s1_ff <= 1'b0;
      vblank_s2_ff <= 1'b0;
      ftg_s1_ff    <= 1'b0;
      ftg_s2_ff    <= 1'b0;
      ftg_s3_ff    <= 1'b0;
      frames_ff    <= 16'h0000;
    end else begin
      ack_s1_ff    <= ack_tgl_px_ff;
      ack_s2_ff    <= ack_s1_ff;
      vblank_s1_ff <= vblank_px_ff;
      vblank_s2_ff <= vblank_s1_ff;
      ftg_s1_ff    <= frame_tgl_px_ff;
      ftg_s2_ff    <= ftg_s1_ff;
      ftg_s3_ff    <= ftg_s2_ff;
      if (ftg_s2_ff ^ ftg_s3_ff) begin
        frames_ff <= frames_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Dot clock domain reset and settings capture
  // ----------------------------------------
  logic        px_meta_ff;
  logic        px_rstn_ff;
  logic        req_s1_ff;
  logic        req_s2_ff;
  logic [31:0] px_ctrl_ff;
  logic [31:0] px_htime_ff;
  logic [31:0] px_vtime_ff;
  logic [31:0] px_pixel_ff;

  // Asynchronous assert, synchronous release
  always_ff @(posedge pix_clk or negedge hresetn) begin
    if (!hresetn) begin
      px_meta_ff <= 1'b0;
      px_rstn_ff <= 1'b0;
    end else begin
      px_meta_ff <= 1'b1;
      px_rstn_ff <= px_meta_ff;
    end
  end

  always_ff @(posedge pix_clk or negedge px_rstn_ff) begin
    if (!px_rstn_ff) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
    end
  end

  // ----------------------------------------
  // Scan geometry
  // ----------------------------------------
  logic             en;
  logic [CNT_W-1:0] h_act;
  logic [CNT_W-1:0] v_act;
  logic [CNT_W-1:0] h_fp_end;
  logic [CNT_W-1:0] h_sync_end;
  logic [CNT_W-1:0] h_total;
  logic [CNT_W-1:0] v_fp_end;
  logic [CNT_W-1:0] v_sync_end;
  logic [CNT_W-1:0] v_total;

  assign en = px_ctrl_ff[CTRL_TYPE_LSB +: 2] != TYPE_OFF;

  always_comb begin
    case (fpt_res_t'(px_ctrl_ff[CTRL_RES_LSB +: 2]))
      RES_800: begin
        h_act = W_800;
        v_act = H_600;
      end
      RES_1024: begin
        h_act = W_1024;
        v_act = H_768;
      end
      default: begin
        h_act = W_640;
        v_act = H_480;
      end
    endcase
  end

  // Horizontal settings are in eight-clock units, vertical in lines
  assign h_fp_end   = h_act + (field8(px_htime_ff, TIM_FP_LSB) << H_UNIT_SH);
  assign h_sync_end = h_fp_end + (field8(px_htime_ff, TIM_SYNC_LSB) << H_UNIT_SH);
  assign h_total    = h_sync_end + (field8(px_htime_ff, TIM_BP_LSB) << H_UNIT_SH);
  assign v_fp_end   = v_act + field8(px_vtime_ff, TIM_FP_LSB);
  assign v_sync_end = v_fp_end + field8(px_vtime_ff, TIM_SYNC_LSB);
  assign v_total    = v_sync_end + field8(px_vtime_ff, TIM_BP_LSB);

  // ----------------------------------------
  // Scan counters
  // ----------------------------------------
  logic [CNT_W-1:0] h_cnt_ff;
  logic [CNT_W-1:0] v_cnt_ff;
  logic             h_last;
  logic             v_last;
  fpt_phase_t       h_ph;
  fpt_phase_t       v_ph;

  // New settings apply from the next counter wrap point they imply;
  // a shrunken total is caught by the >= compare, not missed.
  assign h_last = h_cnt_ff >= h_total - 13'd1;
  assign v_last = v_cnt_ff >= v_total - 13'd1;
  assign h_ph   = phase_of(h_cnt_ff, h_act, h_fp_end, h_sync_end);
  assign v_ph   = phase_of(v_cnt_ff, v_act, v_fp_end, v_sync_end);

  // Settings land only at a line wrap or while off, so no line sync pulse is cut
  always_ff @(posedge pix_clk or negedge px_rstn_ff) begin
    if (!px_rstn_ff) begin
      ack_tgl_px_ff <= 1'b0;
      px_ctrl_ff    <= REG_RESET;
      px_htime_ff   <= REG_RESET;
      px_vtime_ff   <= REG_RESET;
      px_pixel_ff   <= REG_RESET;
    end else if ((req_s2_ff ^ ack_tgl_px_ff) && (h_last || !en)) begin
      ack_tgl_px_ff <= req_s2_ff;
      px_ctrl_ff    <= snap_ctrl_ff;
      px_htime_ff   <= snap_htime_ff;
      px_vtime_ff   <= snap_vtime_ff;
      px_pixel_ff   <= snap_pixel_ff;
    end
  end

  always_ff @(posedge pix_clk or negedge px_rstn_ff) begin
    if (!px_rstn_ff) begin
      h_cnt_ff        <= 13'h0000;
      v_cnt_ff        <= 13'h0000;
      frame_tgl_px_ff <= 1'b0;
    end else if (!en) begin
      h_cnt_ff <= 13'h0000;
      v_cnt_ff <= 13'h0000;
    end else if (h_last) begin
      h_cnt_ff <= 13'h0000;
      if (v_last) begin
        v_cnt_ff        <= 13'h0000;
        frame_tgl_px_ff <= !frame_tgl_px_ff;
      end else begin
        v_cnt_ff <= v_cnt_ff + 13'd1;
      end
    end else begin
      h_cnt_ff <= h_cnt_ff + 13'd1;
    end
  end

  // ----------------------------------------
  // Panel outputs, registered on pix_clk except the forwarded dot_clk_out
  // ----------------------------------------
  logic       vis;
  logic [5:0] nxt_r;
  logic [5:0] nxt_g;
  logic [5:0] nxt_b;

  assign vis = en && (h_ph == PH_ACT) && (v_ph == PH_ACT);

  always_comb begin
    if (px_ctrl_ff[CTRL_PATTERN_BIT]) begin
      nxt_r = {6{h_cnt_ff[8]}};
      nxt_g = {6{h_cnt_ff[7]}};
      nxt_b = {6{h_cnt_ff[6]}};
    end else begin
      nxt_r = px_pixel_ff[PIX_R_LSB +: 6];
      nxt_g = px_pixel_ff[PIX_G_LSB +: 6];
      nxt_b = px_pixel_ff[PIX_B_LSB +: 6];
    end
    // 8 bpp keeps a 3-3-2 colour depth
    if (!px_ctrl_ff[CTRL_BPP16_BIT]) begin
      nxt_r = {nxt_r[5:3], 3'b000};
      nxt_g = {nxt_g[5:3], 3'b000};
      nxt_b = {nxt_b[5:4], 4'b0000};
    end
    if (!vis) begin
      nxt_r = 6'h00;
      nxt_g = 6'h00;
      nxt_b = 6'h00;
    end
  end

  // Clock forwarded untouched; gating it would glitch the panel
  assign dot_clk_out = pix_clk;

  always_ff @(posedge pix_clk or negedge px_rstn_ff) begin
    if (!px_rstn_ff) begin
      red_out             <= 6'h00;
      green_out           <= 6'h00;
      blue_out            <= 6'h00;
      line_sync_out       <= 1'b0;
      frame_sync_out      <= 1'b0;
      active_display_flag <= 1'b0;
      data_enable_out     <= 1'b0;
      backlight_en_out    <= 1'b0;
      panel_vdd_en_out    <= 1'b0;
      vblank_px_ff        <= 1'b0;
    end else begin
      red_out             <= nxt_r;
      green_out           <= nxt_g;
      blue_out            <= nxt_b;
      line_sync_out       <= en && (h_ph == PH_SYNC);
      frame_sync_out      <= en && (v_ph == PH_SYNC);
      active_display_flag <= vis;
      data_enable_out     <= vis;
      backlight_en_out    <= en && px_ctrl_ff[CTRL_BACKLIGHT_BIT];
      panel_vdd_en_out    <= en;
      vblank_px_ff        <= en && (v_ph != PH_ACT);
    end
  end

endmodule

// >>> tb/fpt_chk.sv
// Port-level assertions for the flat panel timing generator.
// Assumes hresetn resets both the hclk and the pix_clk sides.
`timescale 1ns/1ps
module fpt_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic [1:0] hresp,
  input wire logic       pix_clk,
  input wire logic       dot_clk_out,
  input wire logic [5:0] red_out,
  input wire logic [5:0] green_out,
  input wire logic [5:0] blue_out,
  input wire logic       line_sync_out,
  input wire logic       frame_sync_out,
  input wire logic       active_display_flag,
  input wire logic       data_enable_out,
  input wire logic       backlight_en_out,
  input wire logic       panel_vdd_en_out
);
  import fpt_pkg::*;
  // ----------------------------------------
  // Dot clock counter, sync pulse length and bus sequences
  // ----------------------------------------
  logic [7:0]       dot_cnt_ff;
  always_ff @(posedge dot_clk_out or negedge hresetn) begin
    if (!hresetn) dot_cnt_ff <= 8'h00;
    else dot_cnt_ff <= dot_cnt_ff + 8'h01;
  end
  logic [CNT_W-1:0] sync_len_ff;
  always_ff @(posedge pix_clk or negedge hresetn) begin
    if (!hresetn) sync_len_ff <= '0;
    else if (line_sync_out) sync_len_ff <= sync_len_ff + 1'b1;
    else sync_len_ff <= '0;
  end
  sequence s_req;
    hsel && hready && htrans == HTRANS_NSEQ;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_read_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    s_req and !hwrite |=> s_one_wait) else $error("read wait state wrong");
  a_write_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    s_req and hwrite |=> hreadyout) else $error("write stalled");
  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == HRESP_OKAY) else $error("response not okay");
  a_dot_clk_runs: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(dot_cnt_ff) && dot_clk_out == pix_clk) else $error("dot clock not running");
  a_de_is_flag: assert property (@(posedge pix_clk) disable iff (!hresetn)
    data_enable_out == active_display_flag) else $error("enable differs from flag");
  a_blank_black: assert property (@(posedge pix_clk) disable iff (!hresetn)
    !data_enable_out |-> {red_out, green_out, blue_out} == 18'h0_0000)
    else $error("colour outside active area");
  a_sync_in_blank: assert property (@(posedge pix_clk) disable iff (!hresetn)
    line_sync_out || frame_sync_out |-> !data_enable_out) else $error("sync during data");
  a_sync_eights: assert property (@(posedge pix_clk) disable iff (!hresetn)
    $fell(line_sync_out) |-> sync_len_ff[2:0] == 3'h0 && sync_len_ff != '0)
    else $error("line sync not whole units");
  a_off_quiet: assert property (@(posedge pix_clk) disable iff (!hresetn)
    !panel_vdd_en_out [*3] |-> !(line_sync_out || frame_sync_out || data_enable_out
    || backlight_en_out)) else $error("outputs active while off");
endmodule

bind fpt_top fpt_chk i_fpt_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .pix_clk, .dot_clk_out, .red_out, .green_out, .blue_out,
  .line_sync_out, .frame_sync_out, .active_display_flag, .data_enable_out,
  .backlight_en_out, .panel_vdd_en_out);

// >>> tb/fpt_panel_model.sv
// Panel receiver: measures line and frame geometry from the stream it sees.
// Assumes outputs change only after dot clock rising edges.
`timescale 1ns/1ps
module fpt_panel_model (
  input wire logic [5:0] red,
  input wire logic [5:0] green,
  input wire logic [5:0] blue,
  input wire logic       dot_clk,
  input wire logic       line_sync,
  input wire logic       frame_sync,
  input wire logic       de,
  output logic [15:0]    line_len,
  output logic [15:0]    de_len,
  output logic [15:0]    fp_len,
  output logic [15:0]    sync_len,
  output logic [15:0]    pre_lines,
  output logic [15:0]    act_lines,
  output logic [15:0]    vs_lines,
  output logic [15:0]    bp_lines,
  output logic [15:0]    lines = '0,
  output logic [15:0]    done = '0,
  output logic [17:0]    first_rgb
);
  logic [15:0] t = '0, t_ls = '0, t_de = '0, t_def = '0, lc = '0, act = '0;
  logic        ls_q = 1'b0, fs_q = 1'b0, de_q = 1'b0, new_ff = 1'b0, def_seen = 1'b0;
  // Frame anchored at the first data line after vertical sync ends
  always @(posedge dot_clk) begin
    t <= t + 1'b1;
    ls_q <= line_sync;
    fs_q <= frame_sync;
    de_q <= de;
    if (de && !de_q) begin
      t_de <= t;
      first_rgb <= {red, green, blue};
      act <= act + 1'b1;
      if (new_ff) begin
        bp_lines <= lc;
        lc <= '0;
        act <= 16'h0001;
        new_ff <= 1'b0;
        done <= done + 1'b1;
      end
    end
    if (!de && de_q) begin
      de_len <= t - t_de;
      t_def <= t;
      def_seen <= 1'b1;
    end
    if (line_sync && !ls_q) begin
      line_len <= t - t_ls;
      t_ls <= t;
      if (def_seen) fp_len <= t - t_def;
      def_seen <= 1'b0;
      lc <= lc + 1'b1;
      lines <= lines + 1'b1;
    end
    if (!line_sync && ls_q) sync_len <= t - t_ls;
    if (frame_sync && !fs_q) begin
      pre_lines <= lc;
      act_lines <= act;
      lc <= '0;
    end
    if (!frame_sync && fs_q) begin
      vs_lines <= lc;
      lc <= '0;
      new_ff <= 1'b1;
    end
  end
endmodule

// >>> tb/fpt_top_tb_top.sv
// Self-checking bench: AHB-Lite master, panel model, geometry checks.
// Assumes the checker is bound to fpt_top by its own file.
`timescale 1ns/1ps
module fpt_top_tb_top;
  import fpt_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, pix_clk, dot_clk_out;
  logic        line_sync_out, frame_sync_out, active_display_flag, data_enable_out;
  logic        backlight_en_out, panel_vdd_en_out;
  logic [1:0]  htrans, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  dot_clk_mhz;
  logic [5:0]  red_out, green_out, blue_out;
  logic [15:0] line_len, de_len, fp_len, sync_len, pre_lines, act_lines, vs_lines;
  logic [15:0] bp_lines, lines, done;
  logic [17:0] first_rgb;
  int          fail_count, compares;

  fpt_top i_fpt_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dot_clk_mhz, .pix_clk,
    .dot_clk_out, .red_out, .green_out, .blue_out, .line_sync_out, .frame_sync_out,
    .active_display_flag, .data_enable_out, .backlight_en_out, .panel_vdd_en_out);
  fpt_panel_model i_fpt_panel_model (.red(red_out), .green(green_out), .blue(blue_out),
    .dot_clk(dot_clk_out), .line_sync(line_sync_out), .frame_sync(frame_sync_out),
    .de(data_enable_out), .line_len, .de_len, .fp_len, .sync_len, .pre_lines, .act_lines,
    .vs_lines, .bp_lines, .lines, .done, .first_rgb);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Offset phase so the two clock edges never coincide
  initial begin
    pix_clk = 1'b0;
    #3.7;
    forever #6 pix_clk = ~pix_clk;
  end
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Ready sampled mid-cycle, so the value seen is the one at the next edge
  task automatic wait_ready(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (!r) begin
      @(negedge hclk);
      r = (hreadyout === 1'b1);
      d = hrdata;
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= HTRANS_NSEQ;
    wait_ready(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(rd);
  endtask
  task automatic wait_idle();
    logic [31:0] d;
    d = 32'h0000_0001;
    for (int n = 0; n < 200 && d[STAT_BUSY_BIT] !== 1'b0; n++) bus(1'b0, ADDR_STATUS, '0, d);
    check(32'(d[STAT_BUSY_BIT]), 32'h0, "settings transfer");
  endtask
  function automatic logic [17:0] rgb_332(input logic [17:0] p);
    return {p[17:15], 3'h0, p[11:9], 3'h0, p[5:4], 4'h0};
  endfunction
  function automatic logic [31:0] line_total(input logic [31:0] w, f, s, b);
    return w + ((f + s + b) << H_UNIT_SH);
  endfunction
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge hclk);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d, px, f, s, b, vf, vs, vb;
    logic [15:0] n0;
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
    fail_count = 0;
    compares = 0;
    void'($urandom(96391));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({26'h0, panel_vdd_en_out, backlight_en_out, data_enable_out, line_sync_out,
           frame_sync_out, hreadyout}, 32'h0000_0001, "reset outputs");
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'(4 * i), '0, d);
      check(d, REG_RESET, "reset value");
    end
    px = $urandom & 32'h0003_ffff;
    f = 1 + $urandom % 2; s = 1 + $urandom % 2; b = 1 + $urandom % 2;
    vf = 1 + $urandom % 3; vs = 1 + $urandom % 3; vb = 1 + $urandom % 3;
    bus(1'b1, 8'h20, 32'hffff_ffff, d);
    bus(1'b0, 8'h20, '0, d);
    check(d, 32'h0000_0000, "unmapped read");
    bus(1'b1, ADDR_DOTCLK, 32'd25, d);
    bus(1'b1, ADDR_PIXEL, px, d);
    bus(1'b1, ADDR_HTIME, (b << TIM_BP_LSB) | (s << TIM_SYNC_LSB) | f, d);
    bus(1'b1, ADDR_VTIME, (vb << TIM_BP_LSB) | (vs << TIM_SYNC_LSB) | vf, d);
    bus(1'b1, ADDR_CTRL, 32'h0000_1101, d);
    bus(1'b0, ADDR_PIXEL, '0, d);
    check(d, px, "fill colour reg");
    bus(1'b0, ADDR_CTRL, '0, d);
    check(d, 32'h0000_1101, "control reg");
    wait_idle();
    check(32'(dot_clk_mhz), 32'd25, "dot clock rate");
    wait (done !== 16'h0000);
    check(32'(line_len), line_total(640, f, s, b), "line period");
    check(32'(de_len), 32'd640, "active pixels");
    check(32'(fp_len), f << H_UNIT_SH, "front porch");
    check(32'(sync_len), s << H_UNIT_SH, "line sync width");
    check(32'(pre_lines), 480 + vf, "lines before sync");
    check(32'(act_lines), 32'd480, "active lines");
    check(32'(vs_lines), vs, "frame sync lines");
    check(32'(bp_lines), vb, "back porch lines");
    check(32'(pre_lines + vs_lines + bp_lines), 480 + vf + vs + vb, "frame");
    check(32'(first_rgb), px, "pixel colour");
    check(32'(backlight_en_out), 32'h1, "backlight on");
    for (int r = 1; r < 3; r++) begin
      @(posedge hclk);
      bus(1'b1, ADDR_CTRL, (r == 1) ? 32'h0001_1111 : 32'h0000_1021, d);
      wait_idle();
      n0 = lines;
      wait (lines - n0 >= 16'd3);
      check(32'(de_len), (r == 1) ? 32'(W_800) : 32'(W_1024), "width");
      check(32'(first_rgb), (r == 1) ? 32'h0 : 32'(rgb_332(px[17:0])), "mode");
    end
    @(posedge hclk);
    bus(1'b1, ADDR_CTRL, 32'h0000_1000, d);
    wait_idle();
    wait (panel_vdd_en_out === 1'b0);
    repeat (2) @(posedge hclk);
    check({14'h0, red_out, green_out, blue_out, backlight_en_out, data_enable_out,
           line_sync_out, frame_sync_out}, 32'h0, "disabled outputs");
    end_of_test();
  end
endmodule
